/* File: logic/itd_decoder.v */
/*
 Instruction timing decoder top: fetch sequencing, skip handling, mask
 options and an APB register window.
 Assumes opcode bytes from program memory synchronous to pclk, one
 instruction-cycle enable from the core, and a single APB master.
*/
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "itd_map.vh"

module itd_decoder #(
	parameter [1:0] CLK_OPTION = `ITD_CLK_CRYSTAL,
	parameter [1:0] BOD_OPTION = `ITD_BOD_ENABLE
) (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output wire        pready,
	output reg  [31:0] prdata,
	output wire        pslverr,
	input  wire        cycle_en,
	input  wire [7:0]  mem_data,
	output reg  [15:0] mem_addr,
	output reg         fetch_strobe,
	input  wire        cond_false,
	input  wire        clock_out_pin_in,
	output wire        clock_out_pin_drive,
	output wire        port_g_bit7,
	input  wire        brownout_raw,
	output wire        brownout_reset
);

	localparam [1:0] ST_FETCH = 2'h0;
	localparam [1:0] ST_EXEC  = 2'h1;
	localparam [1:0] ST_SKIP  = 2'h2;

	reg  [1:0]  state_q;
	reg  [15:0] pc_q;
	reg  [7:0]  op_q;
	reg  [2:0]  left_q;
	reg  [1:0]  blen_q;
	reg  [2:0]  clen_q;
	reg         undef_q;
	reg         skip_pend_q;
	reg         halt_q;
	reg         done_q;
	reg  [31:0] count_q;
	wire [1:0]  t_bytes;
	wire [2:0]  t_cycles;
	wire        t_undef;
	reg         look_q;

	// Timing lookup, one cycle behind the opcode register
	itd_table u_table (
		.pclk     (pclk),
		.presetn  (presetn),
		.opcode   (op_q),
		.operand  (mem_data),
		.bytes_q  (t_bytes),
		.cycles_q (t_cycles),
		.undef_q  (t_undef),
		.cond_q   ()
	);

	// Short load-B form below the limit is always one byte
	wire ldb_short = (op_q[7:4] == 4'h5) && ({4'h0, op_q[3:0]} < `ITD_LDB_LIMIT);

	// Options are parameters only, never written by software
	assign clock_out_pin_drive = (CLK_OPTION == `ITD_CLK_CRYSTAL);
	assign port_g_bit7 = (CLK_OPTION == `ITD_CLK_CRYSTAL) ? 1'b0 : clock_out_pin_in;
	assign brownout_reset = (BOD_OPTION == `ITD_BOD_ENABLE) & brownout_raw;

	wire wr_acc = psel & penable & pwrite;
	wire ctrl_wr = wr_acc & (paddr == `ITD_OFF_CTRL);
	wire skip_req = (ctrl_wr & pwdata[`ITD_CTRL_SKIP]) | cond_false;

	// Sequencer: fetch, wait a cycle for the table, then count down
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q      <= ST_FETCH;
			pc_q         <= `ITD_PC_RST;
			op_q         <= 8'h00;
			look_q       <= 1'b0;
			left_q       <= 3'h0;
			blen_q       <= 2'h1;
			clen_q       <= 3'h1;
			undef_q      <= 1'b0;
			skip_pend_q  <= 1'b0;
			halt_q       <= 1'b0;
			done_q       <= 1'b0;
			count_q      <= `ITD_ZERO32;
			mem_addr     <= `ITD_PC_RST;
			fetch_strobe <= 1'b0;
		end else begin
			fetch_strobe <= 1'b0;
			done_q <= 1'b0;
			if (ctrl_wr)
				halt_q <= pwdata[`ITD_CTRL_HALT];
			// Set wins over the clear done when the skip starts
			if (skip_req)
				skip_pend_q <= 1'b1;
			case (state_q)
				ST_FETCH: begin
					if (cycle_en && !halt_q) begin
						op_q         <= mem_data;
						mem_addr     <= pc_q;
						fetch_strobe <= 1'b1;
						left_q       <= 3'h0;
						look_q       <= 1'b1;
						state_q      <= skip_pend_q ? ST_SKIP : ST_EXEC;
						if (skip_pend_q && !skip_req)
							skip_pend_q <= 1'b0;
					end
				end
				ST_EXEC: begin
					// The table answers one cycle after the opcode lands
					if (look_q) begin
						look_q <= 1'b0;
					end else if (left_q == 3'h0) begin
						blen_q  <= ldb_short ? 2'h1 : t_bytes;
						clen_q  <= ldb_short ? 3'h1 : t_cycles;
						undef_q <= t_undef;
						left_q  <= ldb_short ? 3'h1 : t_cycles;
					end else if (cycle_en) begin
						if (left_q == 3'h1) begin
							pc_q    <= pc_q + {14'h0000, blen_q};
							done_q  <= 1'b1;
							count_q <= count_q + 32'h00000001;
							state_q <= ST_FETCH;
						end
						left_q <= left_q - 3'h1;
					end
				end
				ST_SKIP: begin
					if (look_q) begin
						look_q <= 1'b0;
					end else if (left_q == 3'h0) begin
						blen_q <= ldb_short ? 2'h1 : t_bytes;
						clen_q <= {1'b0, ldb_short ? 2'h1 : t_bytes};
						left_q <= {1'b0, ldb_short ? 2'h1 : t_bytes};
					end else if (cycle_en) begin
						if (left_q == 3'h1) begin
							pc_q    <= pc_q + {14'h0000, blen_q};
							done_q  <= 1'b1;
							state_q <= ST_FETCH;
						end
						left_q <= left_q - 3'h1;
					end
				end
				default: state_q <= ST_FETCH;
			endcase
		end
	end

	// APB: zero wait states, unmapped reads return zero with error
	wire mapped = (paddr == `ITD_OFF_CTRL) | (paddr == `ITD_OFF_OPCODE) | (paddr == `ITD_OFF_STATUS) |
		(paddr == `ITD_OFF_PC) | (paddr == `ITD_OFF_OPTIONS) | (paddr == `ITD_OFF_COUNT);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Read data registered in the setup phase, valid in the access phase
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= `ITD_ZERO32;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				`ITD_OFF_CTRL:    prdata <= {30'h0, halt_q, skip_pend_q};
				`ITD_OFF_OPCODE:  prdata <= {24'h0, op_q};
				`ITD_OFF_STATUS:  prdata <= {21'h0, clen_q, 2'h0, blen_q, done_q, undef_q,
					(state_q == ST_SKIP), (state_q != ST_FETCH)};
				`ITD_OFF_PC:      prdata <= {16'h0, pc_q};
				`ITD_OFF_OPTIONS: prdata <= {28'h0, BOD_OPTION, CLK_OPTION};
				`ITD_OFF_COUNT:   prdata <= count_q;
				default:          prdata <= `ITD_ZERO32;
			endcase
		end
	end

endmodule // itd_decoder
`default_nettype wire

/* File: logic/itd_map.vh */
/*
 Constants for the instruction timing decoder: load-B threshold, register
 offsets, option codes and field positions.
 Assumes inclusion by bare name from the design files.
*/
`ifndef ITD_MAP_VH
`define ITD_MAP_VH

// Register byte offsets
`define ITD_OFF_CTRL      12'h000
`define ITD_OFF_OPCODE    12'h004
`define ITD_OFF_STATUS    12'h008
`define ITD_OFF_PC        12'h00C
`define ITD_OFF_OPTIONS   12'h010
`define ITD_OFF_COUNT     12'h014

// Control fields
`define ITD_CTRL_SKIP     0
`define ITD_CTRL_HALT     1

// Status fields
`define ITD_ST_BUSY       0
`define ITD_ST_SKIPPING   1
`define ITD_ST_UNDEF      2
`define ITD_ST_DONE       3
`define ITD_ST_BYTES_LO   4
`define ITD_ST_BYTES_HI   5
`define ITD_ST_CYC_LO     8
`define ITD_ST_CYC_HI     10

// Mask option codes
`define ITD_CLK_CRYSTAL   2'h1
`define ITD_CLK_EXTERNAL  2'h2
`define ITD_CLK_RC        2'h3
`define ITD_BOD_ENABLE    2'h1
`define ITD_BOD_DISABLE   2'h2

// Load-B immediate short form threshold
`define ITD_LDB_LIMIT     8'h10

// Reset values
`define ITD_PC_RST        16'h0000
`define ITD_ZERO32        32'h00000000

`endif

/* File: logic/itd_table.v */
/*
 Opcode timing table: byte count, cycle count and undefined flag per opcode,
 held in a registered lookup.
 Assumes a synchronous opcode input on pclk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itd_map.vh"

module itd_table (
	input  wire       pclk,
	input  wire       presetn,
	input  wire [7:0] opcode,
	input  wire [7:0] operand,
	output reg  [1:0] bytes_q,
	output reg  [2:0] cycles_q,
	output reg        undef_q,
	output reg        cond_q
);

	reg [1:0] b_d;
	reg [2:0] c_d;
	reg       u_d;
	reg       k_d;

	// Decode per opcode; undefined codes execute as their aliases
	always @* begin
		b_d = 2'h1;
		c_d = 3'h1;
		u_d = 1'b0;
		k_d = 1'b0;
		casez (opcode)
			8'b0000_0000: c_d = 3'h7;
			8'b0010_????: begin
				b_d = 2'h2;
				c_d = 3'h3;
			end
			8'b0011_????: begin
				b_d = 2'h2;
				c_d = 3'h5;
			end
			8'h4?: c_d = 3'h1;
			// Long load-B timing; the sequencer overrides it with the short form
			8'h5?: begin
				b_d = 2'h2;
				c_d = 3'h3;
			end
			8'h60, 8'h61, 8'h62, 8'h63, 8'h67: u_d = 1'b1;
			8'h6?: c_d = 3'h1;
			8'h7?: k_d = ~opcode[3];
			// Only the relative jumps are left in the low half
			8'b0???_????: c_d = 3'h3;
			8'b1000_0???: k_d = 1'b1;
			8'b1000_1000, 8'b1000_1001: k_d = 1'b1;
			8'h8C: begin
				u_d = 1'b1;
				c_d = 3'h5;
			end
			8'h8D, 8'h8E, 8'h8F: c_d = 3'h5;
			8'b1001_0???: begin
				b_d = 2'h2;
				c_d = 3'h2;
				k_d = (opcode[2:0] == 3'h2) || (opcode[2:0] == 3'h3);
			end
			8'h98: begin
				b_d = 2'h2;
				c_d = 3'h2;
			end
			8'h99: u_d = 1'b1;
			8'h9A, 8'h9B: begin
				b_d = 2'h2;
				c_d = 3'h2;
			end
			8'h9C, 8'h9D: begin
				b_d = 2'h2;
				c_d = 3'h3;
			end
			8'h9E: begin
				b_d = 2'h2;
				c_d = 3'h2;
			end
			8'h9F: begin
				u_d = 1'b1;
				b_d = 2'h2;
				c_d = 3'h2;
			end
			8'hA0, 8'hA1: c_d = 3'h1;
			8'hA2, 8'hA3, 8'hAA, 8'hAB: c_d = 3'h2;
			8'hA4, 8'hA5: c_d = 3'h3;
			8'hA6: c_d = 3'h1;
			8'hA7, 8'hAF: u_d = 1'b1;
			8'hA8, 8'hA9: u_d = 1'b1;
			8'hAC: begin
				b_d = 2'h3;
				c_d = 3'h4;
			end
			8'hAD: begin
				b_d = 2'h3;
				c_d = 3'h5;
			end
			8'hAE: c_d = 3'h1;
			8'hB1, 8'hB4, 8'hB5, 8'hB9: u_d = 1'b1;
			8'hB7, 8'hBF: begin
				u_d = 1'b1;
				c_d = 3'h3;
			end
			8'hB2, 8'hB3, 8'hB6, 8'hBA, 8'hBB, 8'hBE: c_d = 3'h3;
			8'hB8: c_d = 3'h1;
			8'hBC: begin
				b_d = 2'h3;
				c_d = 3'h3;
			end
			8'hBD: begin
				b_d = 2'h3;
				c_d = 3'h4;
				k_d = (operand[7:4] == 4'h2) || (operand[7:4] == 4'h3) || (operand[7:3] == 5'h0E);
			end
			8'hC?: c_d = 3'h3;
			8'hD?: begin
				b_d = 2'h2;
				c_d = 3'h3;
			end
			8'hE?, 8'hF?: c_d = 3'h3;
			default: c_d = 3'h1;
		endcase
	end

	// Registered outputs
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			bytes_q  <= 2'h1;
			cycles_q <= 3'h1;
			undef_q  <= 1'b0;
			cond_q   <= 1'b0;
		end else begin
			bytes_q  <= b_d;
			cycles_q <= c_d;
			undef_q  <= u_d;
			cond_q   <= k_d;
		end
	end

endmodule // itd_table
`default_nettype wire

/* File: verification/itd_checker_assertions.sv */
/*
 Port checker for the decoder top: pins, bus answers, fetch pacing.
 Assumes it is bound into itd_decoder by the bench top.
*/
`timescale 1ns/1ps
`default_nettype none
module itd_checker #(
	parameter [1:0] CLK_OPTION = 2'h1,
	parameter [1:0] BOD_OPTION = 2'h1
) (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	input wire logic        cycle_en,
	input wire logic [15:0] mem_addr,
	input wire logic        fetch_strobe,
	input wire logic        clock_out_pin_in,
	input wire logic        clock_out_pin_drive,
	input wire logic        port_g_bit7,
	input wire logic        brownout_raw,
	input wire logic        brownout_reset
);
	// Six word registers from offset zero
	wire logic map_hit = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0) && (paddr[4:2] < 3'h6);
	wire logic acc     = psel && penable;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_ready_a: assert property (acc |-> pready)
		else $error("no ready in access");
	apb_error_a: assert property (acc |-> pslverr == !map_hit)
		else $error("error flag wrong");
	opt_readback_a: assert property (acc && !pwrite && paddr == 12'h010 |-> prdata[3:0] == {BOD_OPTION, CLK_OPTION})
		else $error("options read wrong");
	crystal_drive_a: assert property (clock_out_pin_drive == (CLK_OPTION == 2'h1))
		else $error("clock pin drive wrong");
	pin_route_a: assert property (port_g_bit7 == ((CLK_OPTION != 2'h1) && clock_out_pin_in))
		else $error("port pin route wrong");
	bod_gate_a: assert property (brownout_reset == (brownout_raw && (BOD_OPTION == 2'h1)))
		else $error("brownout gate wrong");
	fetch_gap_a: assert property (fetch_strobe |=> !fetch_strobe [*3])
		else $error("fetches too close");
	fetch_cause_a: assert property (fetch_strobe |-> $past(cycle_en))
		else $error("fetch without cycle");
	addr_move_a: assert property (!$stable(mem_addr) |-> fetch_strobe)
		else $error("address moved off fetch");
	fetch_c: cover property (fetch_strobe);
	error_c: cover property (acc && pslverr);
	opt_c: cover property (acc && !pwrite && paddr == 12'h010);
endmodule // itd_checker
`default_nettype wire

/* File: verification/itd_decoder_tb.sv */
/*
 Self-checking bench: program stream with byte and cycle model, option reads.
 Assumes the design, checker and memory files compile first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "itd_map.vh"
module itd_decoder_tb;
	localparam int NP = 20;
	localparam int SK = 6;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cycle_en, fetch_strobe, cond_false, err;
	logic        clock_out_pin_in, clock_out_pin_drive, port_g_bit7, brownout_raw, brownout_reset;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] mem_addr, pc = 16'h0000;
	logic [7:0]  mem_data;
	int          error_cnt = 0, checked = 0, k = 0, ph = 0, cnt = 0, n;
	// Opcode, bytes, cycles per slot; slot SK is skipped and costs its bytes
	logic [7:0]  op [NP] = '{8'hB8, 8'h64, 8'h94, 8'h84, 8'hA4, 8'hAC, 8'hAD, 8'h00, 8'h8E, 8'hC0,
		8'hBF, 8'h8C, 8'h60, 8'h9F, 8'h5F, 8'hDE, 8'hA2, 8'hB2, 8'hB7, 8'hA7};
	int          nb [NP] = '{1, 1, 2, 1, 1, 3, 3, 1, 1, 1, 1, 1, 1, 2, 1, 2, 1, 1, 1, 1};
	int          nc [NP] = '{1, 1, 2, 1, 3, 4, 5, 7, 5, 3, 3, 5, 1, 2, 1, 3, 2, 3, 3, 1};
	itd_decoder #(.CLK_OPTION(`ITD_CLK_EXTERNAL), .BOD_OPTION(`ITD_BOD_ENABLE)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .cycle_en(cycle_en),
		.mem_data(mem_data), .mem_addr(mem_addr), .fetch_strobe(fetch_strobe), .cond_false(cond_false),
		.clock_out_pin_in(clock_out_pin_in), .clock_out_pin_drive(clock_out_pin_drive),
		.port_g_bit7(port_g_bit7), .brownout_raw(brownout_raw), .brownout_reset(brownout_reset));
	itd_prog_mem #(.NP(NP)) mem (.pclk(pclk), .presetn(presetn), .fetch_strobe(fetch_strobe), .mem_data(mem_data));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		chk(t < 50, 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic conclude();
		$display("errors %0d checks %0d", error_cnt, checked);
		if (error_cnt == 0 && checked > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// Irregular core pace and pin noise
	always @(posedge pclk) begin
		cycle_en <= 2'($urandom) != 2'h0;
		{clock_out_pin_in, brownout_raw} <= 2'($urandom);
	end
	// Score an instruction when the next fetch appears; pulses counted from the third edge
	always @(posedge pclk) begin
		cond_false <= presetn && !fetch_strobe && ph == 2 && k == SK;
		if (presetn && fetch_strobe) begin
			if (k > 0) chk(cnt, (k > NP) ? 2 : ((k - 1 == SK) ? nb[k - 1] : nc[k - 1]) + 1);
			chk(mem_addr, pc);
			pc = pc + 16'((k < NP) ? nb[k] : 1);
			k++;
			ph = 1;
			cnt = 0;
		end else if (presetn) begin
			ph++;
			if (ph >= 3 && cycle_en) cnt++;
		end
	end
	initial begin
		void'($urandom(97064));
		{presetn, psel, penable, pwrite, paddr, pwdata, cycle_en, cond_false, clock_out_pin_in, brownout_raw} = '0;
		for (n = 0; n < NP; n++) mem.prog[n] = op[n];
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		for (n = 0; n < 4000 && k <= NP; n++) @(posedge pclk);
		chk(k > NP, 1'b1);
		apb(1'b1, `ITD_OFF_OPTIONS, 32'hFFFFFFFF, rd, err);
		apb(1'b0, `ITD_OFF_OPTIONS, 32'h0, rd, err);
		chk(rd, {28'h0, 2'h1, 2'h2});
		chk(err, 1'b0);
		apb(1'b1, 12'h018, 32'h0000000F, rd, err);
		apb(1'b0, 12'h018, 32'h0, rd, err);
		chk(err, 1'b1);
		chk(rd, 32'h0);
		// Halt lets the running instruction end, then fetching stops for good
		apb(1'b1, `ITD_OFF_CTRL, 32'h00000002, rd, err);
		repeat (40) @(posedge pclk);
		apb(1'b0, `ITD_OFF_PC, 32'h0, rd, err);
		chk(rd, {16'h0000, pc});
		apb(1'b0, `ITD_OFF_COUNT, 32'h0, rd, err);
		chk(rd, k - 1);
		conclude();
	end
endmodule // itd_decoder_tb
bind itd_decoder itd_checker #(.CLK_OPTION(CLK_OPTION), .BOD_OPTION(BOD_OPTION)) chk_i (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pready(pready), .prdata(prdata), .pslverr(pslverr), .cycle_en(cycle_en), .mem_addr(mem_addr),
	.fetch_strobe(fetch_strobe), .clock_out_pin_in(clock_out_pin_in), .clock_out_pin_drive(clock_out_pin_drive),
	.port_g_bit7(port_g_bit7), .brownout_raw(brownout_raw), .brownout_reset(brownout_reset));
`default_nettype wire

/* File: verification/itd_prog_mem.sv */
/*
 Program memory stand-in: one opcode byte per fetch, in program order.
 Assumes the bench fills prog before reset is released.
*/
`timescale 1ns/1ps
`default_nettype none
module itd_prog_mem #(
	parameter int NP = 20
) (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic       fetch_strobe,
	output logic     [7:0] mem_data
);
	logic [7:0] prog [0:NP-1];
	int         idx;
	// Step on after the fetch edge, so the byte stands while it is taken
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) idx <= 0;
		else if (fetch_strobe) idx <= idx + 1;
	end
	// Past the program only defined no-op bytes are offered
	assign mem_data = (idx < NP) ? prog[idx] : 8'hB8;
endmodule // itd_prog_mem
`default_nettype wire
